// File: bench/blc_link_checker.sv
// Link checker: watches the byte link between host end and device end.
// Assumes blc_pkg compiled first; instantiated beside the link in tb_top.
`timescale 1ns/1ps
`default_nettype none
module blc_link_checker
  import blc_pkg::*;
(
  // Clock and reset
  input wire logic       mclk,
  input wire logic       reset,
  // Link signals
  input wire logic [7:0] h2d_byte,
  input wire logic       h2d_valid,
  input wire logic [7:0] d2h_byte,
  input wire logic       d2h_valid
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  ////////////////////////////////////////////////////////////////////////////
  // Packet shapes; a host start byte must follow an idle cycle, so payload bytes
  // that happen to look like a length are not taken as a new packet
  sequence s_short;
    h2d_valid && !$past(h2d_valid) && h2d_byte == LEN_SHORT ##1 h2d_valid
      ##1 h2d_valid && h2d_byte == $past(h2d_byte);
  endsequence
  sequence s_status;
    d2h_valid && d2h_byte == LEN_SHORT ##1 d2h_valid
      ##1 d2h_valid && d2h_byte == $past(d2h_byte);
  endsequence
  sequence s_long(logic [7:0] code);
    h2d_valid && !$past(h2d_valid) && h2d_byte == LEN_LONG ##1 h2d_valid
      ##1 h2d_valid && h2d_byte == code ##1 h2d_valid [*8];
  endsequence
  sequence s_run;
    h2d_valid && !$past(h2d_valid) && h2d_byte == LEN_RUN ##1 h2d_valid
      ##1 h2d_valid && h2d_byte == CMD_RUN ##1 h2d_valid [*4];
  endsequence

  ////////////////////////////////////////////////////////////////////////////
  // Answers and ordering on the wire
  chk_short_ack: assert property (s_short |-> ##3 d2h_valid && d2h_byte == BLC_ACK)
    else $error("short packet not acknowledged three cycles later");
  chk_query_pkt: assert property ((s_short ##0 h2d_byte == LAST_RESULT_QUERY_CMD) |->
    ##3 d2h_valid && d2h_byte == BLC_ACK ##1 s_status)
    else $error("query not followed by ack and one-byte status packet");
  chk_status_reply: assert property (s_status |-> ##[1:16] h2d_valid && h2d_byte == BLC_ACK)
    else $error("status packet not answered by host");
  chk_run_ack: assert property (s_run |-> ##3 d2h_valid && d2h_byte == BLC_ACK)
    else $error("run packet not acknowledged");
  chk_erase_ack: assert property (s_long(CMD_DOWNLOAD) |->
    ##[2:300] d2h_valid && d2h_byte == BLC_ACK)
    else $error("download packet not acknowledged in time");
  chk_send_ack: assert property (s_long(CMD_SEND_DATA) |->
    ##[2:12] d2h_valid && d2h_byte == BLC_ACK)
    else $error("send data packet not acknowledged in time");
  chk_len_cap: assert property (h2d_valid && !$past(h2d_valid) && h2d_byte != BLC_ACK
    && h2d_byte != BLC_NAK |-> h2d_byte >= LEN_SHORT && h2d_byte <= LEN_LONG)
    else $error("packet length outside three to eleven");
  chk_half_duplex: assert property (h2d_valid |-> !d2h_valid)
    else $error("device talks while host sends");
endmodule
`default_nettype wire

// File: bench/tb_top.sv
// Testbench: host end joined to device end, and a second device end fed raw.
// Assumes blc_pkg, blc_link_if, both ends and the checker compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import blc_pkg::*;
  logic        mclk, reset, cmd_go, busy_r, done_r, acked_r, status_valid_r;
  logic [7:0]  cmd_code, status_r, prog_data_r, result_r, ecnt;
  logic [31:0] cmd_addr, cmd_size, erase_addr_r, erase_size_r, prog_addr_r, run_addr_r;
  logic [31:0] pa_b, b_addr;
  logic [63:0] cmd_data;
  logic [3:0]  cmd_nbytes;
  logic        erase_req_r, erase_done, erase_ok, prog_we_r, prog_err, run_req_r;
  logic        soft_reset_r, er_b, ed_b, we_b, run_on_ack, soft_seen;
  logic [7:0]  h2d_q[$], d2h_q[$], mem[logic [31:0]];
  int          n_errors, compares, n_writes;

  blc_link_if lk (.mclk(mclk));
  blc_link_if lk_b (.mclk(mclk));
  blc_host_end u_blc_host_end (.mclk(mclk), .reset(reset), .link(lk), .cmd_go(cmd_go),
    .cmd_code(cmd_code), .cmd_addr(cmd_addr), .cmd_size(cmd_size), .cmd_data(cmd_data),
    .cmd_nbytes(cmd_nbytes), .busy_r(busy_r), .done_r(done_r), .acked_r(acked_r),
    .status_valid_r(status_valid_r), .status_r(status_r));
  blc_dev_end u_blc_dev_end (.mclk(mclk), .reset(reset), .link(lk), .erase_req_r(erase_req_r),
    .erase_addr_r(erase_addr_r), .erase_size_r(erase_size_r), .erase_done(erase_done),
    .erase_ok(erase_ok), .prog_we_r(prog_we_r), .prog_addr_r(prog_addr_r),
    .prog_data_r(prog_data_r), .prog_err(prog_err), .run_req_r(run_req_r),
    .run_addr_r(run_addr_r), .soft_reset_r(soft_reset_r), .result_r(result_r));
  blc_dev_end u_blc_dev_end_b (.mclk(mclk), .reset(reset), .link(lk_b), .erase_req_r(er_b),
    .erase_addr_r(), .erase_size_r(), .erase_done(ed_b), .erase_ok(1'b1), .prog_we_r(we_b),
    .prog_addr_r(pa_b), .prog_data_r(), .prog_err(1'b0), .run_req_r(), .run_addr_r(),
    .soft_reset_r(), .result_r());
  blc_link_checker u_blc_link_checker (.mclk(mclk), .reset(reset), .h2d_byte(lk.h2d_byte),
    .h2d_valid(lk.h2d_valid), .d2h_byte(lk.d2h_byte), .d2h_valid(lk.d2h_valid));

  ////////////////////////////////////////////////////////////////////////////
  // Clock, 40 ns period
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  // Flash stub: a slow erase on the main pair so the late ack is visible
  always @(posedge mclk) begin
    ecnt <= erase_req_r ? ecnt + 8'h01 : 8'h00;
    erase_done <= (ecnt == 8'h05);
    ed_b <= er_b && !ed_b;
  end

  // Monitor, sampling what the ends themselves sample on the edge
  always @(posedge mclk) begin
    if (lk.h2d_valid) h2d_q.push_back(lk.h2d_byte);
    if (lk.d2h_valid) d2h_q.push_back(lk.d2h_byte);
    if (prog_we_r) begin
      mem[prog_addr_r] = prog_data_r;
      n_writes++;
    end
    if (run_req_r) run_on_ack = lk.d2h_valid && lk.d2h_byte === BLC_ACK;
    if (soft_reset_r) soft_seen = 1'b1;
    if (we_b) b_addr = pa_b;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shared helpers
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic chk_q(input logic [7:0] s[$], input logic [7:0] e[$]);
    check(s.size(), e.size());
    foreach (e[i]) check(s[i], e[i]);
  endtask

  function automatic logic [7:0] sum8(input logic [7:0] q[$]);
    logic [7:0] s;
    s = 8'h00;
    foreach (q[i]) s = s + q[i];
    return s;
  endfunction

  // One command through the host end; waits for done off the edge
  task automatic run_cmd(input logic [7:0] c, input logic [31:0] a, s,
                         input logic [63:0] d, input logic [3:0] n);
    int i;
    @(posedge mclk);
    cmd_code <= c;
    cmd_addr <= a;
    cmd_size <= s;
    cmd_data <= d;
    cmd_nbytes <= n;
    cmd_go <= 1'b1;
    h2d_q.delete();
    d2h_q.delete();
    @(posedge mclk);
    cmd_go <= 1'b0;
    i = 0;
    while (done_r !== 1'b1 && i < 600) begin
      @(negedge mclk);
      i++;
    end
    check({i < 600, busy_r}, 2'b10);
    repeat (3) @(negedge mclk);
  endtask

  task automatic query(input logic [7:0] e);
    run_cmd(LAST_RESULT_QUERY_CMD, 32'h0, 32'h0, 64'h0, 4'h0);
    check(status_valid_r, 1'b1);
    check(status_r, e);
    chk_q(d2h_q, {BLC_ACK, LEN_SHORT, e, e});
    check(h2d_q[h2d_q.size() - 1], BLC_ACK);
  endtask

  task automatic send(input logic [63:0] d, input logic [3:0] n);
    run_cmd(CMD_SEND_DATA, 32'h0, 32'h0, d, n);
    check(h2d_q[0], {4'h0, (n > 4'h8) ? 4'h8 : n} + LEN_SHORT);
    check(h2d_q[2], CMD_SEND_DATA);
    check(acked_r, 1'b1);
  endtask

  task automatic dl(input logic [31:0] a, s, input logic [7:0] e);
    logic [7:0] d[$];
    d = {CMD_DOWNLOAD, a[31:24], a[23:16], a[15:8], a[7:0], s[31:24], s[23:16], s[15:8], s[7:0]};
    run_cmd(CMD_DOWNLOAD, a, s, 64'h0, 4'h0);
    chk_q(h2d_q, {LEN_LONG, sum8(d), d});
    if (e != RES_INVALID) check(erase_addr_r - erase_size_r, a - s);
    query(e);
  endtask

  // Raw bytes into the second device end; released data shows inverted
  task automatic raw(input logic [7:0] b[$], input logic [7:0] e);
    int i;
    foreach (b[k]) begin
      @(posedge mclk);
      lk_b.h2d_byte <= b[k];
      lk_b.h2d_valid <= 1'b1;
    end
    @(posedge mclk);
    lk_b.h2d_valid <= 1'b0;
    lk_b.h2d_byte <= ~b[b.size() - 1];
    i = 0;
    while (lk_b.d2h_valid !== 1'b1 && i < 300) begin
      @(negedge mclk);
      i++;
    end
    check(lk_b.d2h_byte, e);
    repeat (2) @(negedge mclk);
  endtask

  task final_report;
    if (n_errors == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_program;
    send(64'h5A00000000000000, 4'h1);
    query(RES_FAIL);
    check(n_writes, 0);
    dl(32'h00000100, 32'h0000000A, RES_SUCCESS);
    send(64'h1122334455667788, 4'hF);
    query(RES_SUCCESS);
    send(64'h99AA000000000000, 4'h2);
    check(n_writes, 10);
    check(mem[32'h107], 8'h88);
    check({mem[32'h108], mem[32'h109]}, 16'h99AA);
    send(64'h7700000000000000, 4'h1);
    query(RES_FAIL);
    check(n_writes, 10);
  endtask

  task automatic t_faults;
    dl(32'h00020000, 32'h00000004, RES_INVALID);
    @(posedge mclk) erase_ok <= 1'b0;
    dl(32'h00000200, 32'h00000004, RES_FAIL);
    @(posedge mclk) erase_ok <= 1'b1;
    dl(32'h00000200, 32'h00000004, RES_SUCCESS);
    @(posedge mclk) prog_err <= 1'b1;
    send(64'h6600000000000000, 4'h1);
    query(RES_FAIL);
    @(posedge mclk) prog_err <= 1'b0;
    run_cmd(8'h30, 32'h0, 32'h0, 64'h0, 4'h0);
    query(RES_UNKNOWN);
    run_cmd(CMD_PING, 32'h0, 32'h0, 64'h0, 4'h0);
    chk_q(h2d_q, {LEN_SHORT, CMD_PING, CMD_PING});
    check(result_r, RES_SUCCESS);
  endtask

  task automatic t_run_reset;
    logic [7:0] d[$];
    d = {CMD_RUN, 8'h12, 8'h34, 8'h56, 8'h78};
    run_cmd(CMD_RUN, 32'h12345678, 32'h0, 64'h0, 4'h0);
    chk_q(h2d_q, {LEN_RUN, sum8(d), d});
    check(run_on_ack, 1'b1);
    check(run_addr_r, 32'h12345678);
    run_cmd(8'h31, 32'h0, 32'h0, 64'h0, 4'h0);
    run_cmd(CMD_RESET, 32'h0, 32'h0, 64'h0, 4'h0);
    check(soft_seen, 1'b1);
    chk_q(d2h_q, {BLC_ACK});
    check(result_r, RES_SUCCESS);
  endtask

  task automatic t_reject;
    raw({8'h00, 8'h00, LEN_SHORT, CMD_PING, CMD_PING}, BLC_ACK);
    raw({LEN_SHORT, 8'h21, CMD_PING}, BLC_NAK);
    raw({LEN_LONG, 8'h27, CMD_DOWNLOAD, 8'h00, 8'h00, 8'h02, 8'h00,
         8'h00, 8'h00, 8'h00, 8'h04}, BLC_ACK);
    raw({8'h04, 8'h00, CMD_SEND_DATA, 8'hAA}, BLC_NAK);
    raw({8'h04, 8'hCE, CMD_SEND_DATA, 8'hAA}, BLC_ACK);
    check(b_addr, 32'h00000200);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog, well above the few hundred cycles the run needs
  initial begin
    repeat (20000) @(posedge mclk);
    n_errors++;
    final_report();
  end

  // Main sequence
  initial begin
    {reset, cmd_go, erase_ok, prog_err, erase_done, ed_b} = 6'b101000;
    {cmd_code, cmd_addr, cmd_size, cmd_data, cmd_nbytes, ecnt} = '0;
    lk_b.h2d_valid = 1'b0;
    lk_b.h2d_byte = 8'h00;
    {n_errors, compares, n_writes, soft_seen, run_on_ack, b_addr} = '1;
    {n_errors, compares, n_writes, soft_seen, run_on_ack} = '0;
    repeat (8) @(posedge mclk);
    reset <= 1'b0;
    t_program();
    t_faults();
    t_run_reset();
    t_reject();
    final_report();
  end
endmodule
`default_nettype wire

// File: hw/blc_dev_end.sv
// Boot loader command engine, device end: parses packets, drives flash.
// Assumes the host end on blc_link_if and a flash controller on mclk.
// Operation
// - First data byte is command, rest parameters
// - Ping sets result to success
// - Host ping checksum equals command byte
// - Query acknowledged, then one-byte result packet
// - Host answers result packet with ack/nak
// - Host queries result after every command (the host end never issues the query itself; it is left to its user)
// - Download: 11 bytes, address, count MSB first
// - Download erases area before answering
// - Host queries result after download
// - Send data only after download/send data (code also accepts it after a last-result query)
// - Programming address advances across packets
// - Host sends at most eight payload bytes
// - Programming ends when byte count reached
// - Rejected packet leaves address unchanged
// - Run: 7 bytes, address MSB first
// - Run acknowledges before jumping
// - Reset acknowledges, then resets itself
// - Length byte first, then data checksum
// - Ack 0xCC on good packet, nak 0x33
// - Leading zero bytes are ignored
`timescale 1ns/1ps
`default_nettype none
module blc_dev_end #(
  parameter logic [31:0] FLASH_BASE  = 32'h00000000,
  parameter logic [31:0] FLASH_BYTES = 32'h00010000
) (
  // Clock and reset
  input  wire logic          mclk,
  input  wire logic          reset,
  // Link to host end
  blc_link_if.dev            link,
  // Erase handshake
  output logic               erase_req_r,
  output logic [31:0]        erase_addr_r,
  output logic [31:0]        erase_size_r,
  input  wire logic          erase_done,
  input  wire logic          erase_ok,
  // Byte programming
  output logic               prog_we_r,
  output logic [31:0]        prog_addr_r,
  output logic [7:0]         prog_data_r,
  input  wire logic          prog_err,
  // Execution control
  output logic               run_req_r,
  output logic [31:0]        run_addr_r,
  output logic               soft_reset_r,
  output logic [7:0]         result_r
);
  import blc_pkg::*;

  blc_dev_state_t state_r;
  logic [7:0]  len_r;
  logic [7:0]  sum_r;
  logic [7:0]  acc_r;
  logic [7:0]  cnt_r;
  logic [7:0]  buf_r [0:BUF_BYTES-1];
  logic        good_r;
  logic        window_r;
  logic        fail_r;
  logic [31:0] next_addr_r;
  logic [31:0] remain_r;
  logic [3:0]  idx_r;
  logic [7:0]  d2h_byte_r;
  logic        d2h_valid_r;

  assign link.d2h_byte  = d2h_byte_r;
  assign link.d2h_valid = d2h_valid_r;

  ////////////////////////////////////////////////////////////////////////
  // Decode of the received packet
  wire        rx_nz    = link.h2d_valid && (link.h2d_byte != 8'h00);
  wire [7:0]  cmd      = buf_r[0];
  wire [31:0] par_a    = {buf_r[1], buf_r[2], buf_r[3], buf_r[4]};
  wire [31:0] par_b    = {buf_r[5], buf_r[6], buf_r[7], buf_r[8]};
  wire [7:0]  data_cnt = len_r - LEN_HDR;
  wire        last_dat = (cnt_r + 8'h01) == data_cnt;
  wire [7:0]  acc_nxt  = acc_r + link.h2d_byte;
  wire        is_short = (cmd == CMD_PING) || (cmd == LAST_RESULT_QUERY_CMD)
                         || (cmd == CMD_RESET);
  wire        is_known = is_short || (cmd == CMD_DOWNLOAD) || (cmd == CMD_RUN)
                         || (cmd == CMD_SEND_DATA);
  // Known commands must carry their own length; unknown ones are only sized
  wire        len_ok   = (len_r >= LEN_SHORT)
                         && (!is_short || len_r == LEN_SHORT)
                         && (cmd != CMD_DOWNLOAD || len_r == LEN_LONG)
                         && (cmd != CMD_RUN || len_r == LEN_RUN)
                         && (cmd != CMD_SEND_DATA || len_r <= LEN_LONG);
  wire        pkt_good = len_ok && (acc_r == sum_r);
  // Window must lie wholly inside the flash
  wire [32:0] win_end  = {1'b0, par_a} + {1'b0, par_b};
  wire [32:0] fl_end   = {1'b0, FLASH_BASE} + {1'b0, FLASH_BYTES};
  wire        win_ok   = (par_a >= FLASH_BASE) && (win_end <= fl_end);
  wire [3:0]  pay_cnt  = 4'(len_r - LEN_SHORT);
  wire        prog_more = (idx_r < pay_cnt) && (remain_r != 32'h0);

  ////////////////////////////////////////////////////////////////////////
  // Packet reception: length, sum, data bytes
  always_ff @(posedge mclk) begin
    if (reset || soft_reset_r) begin
      len_r <= 8'h00;
      sum_r <= 8'h00;
      acc_r <= 8'h00;
      cnt_r <= 8'h00;
    end else if (state_r == BLC_IDLE && rx_nz) begin
      len_r <= link.h2d_byte;
    end else if (state_r == BLC_SUM && link.h2d_valid) begin
      sum_r <= link.h2d_byte;
      acc_r <= 8'h00;
      cnt_r <= 8'h00;
    end else if (state_r == BLC_DATA && link.h2d_valid) begin
      acc_r <= acc_nxt;
      cnt_r <= cnt_r + 8'h01;
    end
  end

  // Only the first bytes are kept; longer packets are still counted
  genvar gi;
  generate
    for (gi = 0; gi < BUF_BYTES; gi = gi + 1) begin : g_buf
      always_ff @(posedge mclk) begin
        if (reset) begin
          buf_r[gi] <= 8'h00;
        end else if (state_r == BLC_DATA && link.h2d_valid && cnt_r == 8'(gi)) begin
          buf_r[gi] <= link.h2d_byte;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Command sequencer
  always_ff @(posedge mclk) begin
    if (reset || soft_reset_r) begin
      state_r      <= BLC_IDLE;
      good_r       <= 1'b0;
      window_r     <= 1'b0;
      fail_r       <= 1'b0;
      next_addr_r  <= 32'h0;
      remain_r     <= 32'h0;
      idx_r        <= 4'h0;
      result_r     <= RES_SUCCESS;
      erase_req_r  <= 1'b0;
      erase_addr_r <= 32'h0;
      erase_size_r <= 32'h0;
      prog_we_r    <= 1'b0;
      prog_addr_r  <= 32'h0;
      prog_data_r  <= 8'h00;
      run_req_r    <= 1'b0;
      run_addr_r   <= 32'h0;
      soft_reset_r <= 1'b0;
      d2h_byte_r   <= 8'h00;
      d2h_valid_r  <= 1'b0;
    end else begin
      d2h_valid_r <= 1'b0;
      prog_we_r   <= 1'b0;
      run_req_r   <= 1'b0;
      case (state_r)
        BLC_IDLE: begin
          if (rx_nz) begin
            state_r <= BLC_SUM;
          end
        end
        BLC_SUM: begin
          if (link.h2d_valid) begin
            state_r <= (len_r > LEN_HDR) ? BLC_DATA : BLC_EXEC;
          end
        end
        BLC_DATA: begin
          if (link.h2d_valid && last_dat) begin
            state_r <= BLC_EXEC;
          end
        end
        BLC_EXEC: begin
          good_r  <= pkt_good;
          state_r <= BLC_ANSW;
          // A rejected packet changes nothing, address included
          if (pkt_good) begin
            window_r <= window_r && (cmd == LAST_RESULT_QUERY_CMD);
            if (!is_known) begin
              result_r <= RES_UNKNOWN;
            end else if (cmd == CMD_PING) begin
              result_r <= RES_SUCCESS;
            end else if (cmd == CMD_DOWNLOAD) begin
              if (win_ok) begin
                erase_req_r  <= 1'b1;
                erase_addr_r <= par_a;
                erase_size_r <= par_b;
                next_addr_r  <= par_a;
                remain_r     <= par_b;
                state_r      <= BLC_ERASE;
              end else begin
                result_r <= RES_INVALID;
              end
            end else if (cmd == CMD_SEND_DATA) begin
              if (window_r) begin
                idx_r   <= 4'h0;
                fail_r  <= 1'b0;
                state_r <= BLC_PROG;
              end else begin
                result_r <= RES_FAIL;
              end
            end else if (cmd == CMD_RUN) begin
              run_addr_r <= par_a;
              result_r   <= RES_SUCCESS;
            end
          end
        end
        BLC_ERASE: begin
          // Answer is held back until the whole window is erased
          if (erase_done) begin
            erase_req_r <= 1'b0;
            window_r    <= erase_ok;
            result_r    <= erase_ok ? RES_SUCCESS : RES_FAIL;
            state_r     <= BLC_ANSW;
          end
        end
        BLC_PROG: begin
          fail_r <= fail_r || prog_err;
          if (prog_more && (pay_cnt <= PAYLOAD_MAX)) begin
            prog_we_r   <= 1'b1;
            prog_addr_r <= next_addr_r;
            prog_data_r <= buf_r[idx_r + 4'h1];
            next_addr_r <= next_addr_r + 32'h1;
            remain_r    <= remain_r - 32'h1;
            idx_r       <= idx_r + 4'h1;
          end else begin
            // Bytes beyond the window count are dropped
            window_r <= (remain_r != 32'h0) && !fail_r && !prog_err;
            result_r <= (fail_r || prog_err) ? RES_FAIL : RES_SUCCESS;
            state_r  <= BLC_ANSW;
          end
        end
        BLC_ANSW: begin
          d2h_valid_r <= 1'b1;
          d2h_byte_r  <= good_r ? BLC_ACK : BLC_NAK;
          state_r     <= BLC_IDLE;
          if (good_r && cmd == LAST_RESULT_QUERY_CMD) begin
            state_r <= BLC_STLEN;
          end
          if (good_r && cmd == CMD_RUN) begin
            run_req_r <= 1'b1;
          end
          if (good_r && cmd == CMD_RESET) begin
            soft_reset_r <= 1'b1;
          end
        end
        BLC_STLEN: begin
          d2h_valid_r <= 1'b1;
          d2h_byte_r  <= LEN_SHORT;
          state_r     <= BLC_STSUM;
        end
        BLC_STSUM: begin
          d2h_valid_r <= 1'b1;
          d2h_byte_r  <= result_r;
          state_r     <= BLC_STDAT;
        end
        BLC_STDAT: begin
          d2h_valid_r <= 1'b1;
          d2h_byte_r  <= result_r;
          state_r     <= BLC_STACK;
        end
        BLC_STACK: begin
          // Ack or nak alike ends the query; the host end does not repeat it
          if (rx_nz) begin
            state_r <= BLC_IDLE;
          end
        end
        default: begin
          state_r <= BLC_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// File: hw/blc_host_end.sv
// Boot loader command engine, host end: frames commands, reads answers.
// Assumes the device end on blc_link_if and a user issuing one command.
`timescale 1ns/1ps
`default_nettype none
module blc_host_end (
  // Clock and reset
  input  wire logic          mclk,
  input  wire logic          reset,
  // Link to device end
  blc_link_if.host           link,
  // Command request
  input  wire logic          cmd_go,
  input  wire logic [7:0]    cmd_code,
  input  wire logic [31:0]   cmd_addr,
  input  wire logic [31:0]   cmd_size,
  input  wire logic [63:0]   cmd_data,
  input  wire logic [3:0]    cmd_nbytes,
  // Command outcome
  output logic               busy_r,
  output logic               done_r,
  output logic               acked_r,
  output logic               status_valid_r,
  output logic [7:0]         status_r
);
  import blc_pkg::*;

  typedef enum logic [3:0] {
    HST_IDLE = 4'b0000,
    HST_LEN  = 4'b0001,
    HST_SUM  = 4'b0010,
    HST_BODY = 4'b0011,
    HST_WAIT = 4'b0100,
    HST_RLEN = 4'b0101,
    HST_RSUM = 4'b0110,
    HST_RDAT = 4'b0111,
    HST_REPL = 4'b1000
  } blc_host_state_t;

  blc_host_state_t state_r;
  logic [7:0] body_r [0:BUF_BYTES-1];
  logic [7:0] nbody_r;
  logic [7:0] idx_r;
  logic [7:0] rsum_r;
  logic [7:0] h2d_byte_r;
  logic       h2d_valid_r;

  assign link.h2d_byte  = h2d_byte_r;
  assign link.h2d_valid = h2d_valid_r;

  ////////////////////////////////////////////////////////////////////////
  // Frame layout and checksum
  wire        is_dl   = cmd_code == CMD_DOWNLOAD;
  wire        is_send = cmd_code == CMD_SEND_DATA;
  wire [3:0]  pay_n   = (cmd_nbytes > PAYLOAD_MAX) ? PAYLOAD_MAX : cmd_nbytes;
  wire [7:0]  body_n  = is_dl ? (LEN_LONG - LEN_HDR) :
                        (cmd_code == CMD_RUN) ? (LEN_RUN - LEN_HDR) :
                        is_send ? (8'h01 + 8'(pay_n)) : (LEN_SHORT - LEN_HDR);
  wire [63:0] params  = is_send ? cmd_data : {cmd_addr, cmd_size};
  wire [7:0]  body_w [0:BUF_BYTES-1];
  wire [7:0]  part_w [0:BUF_BYTES];
  wire        rx_nz   = link.d2h_valid && (link.d2h_byte != 8'h00);

  assign body_w[0] = cmd_code;
  assign part_w[0] = 8'h00;
  // Ping sums to its own command byte, so no special case is needed
  genvar gi;
  generate
    for (gi = 0; gi < BUF_BYTES; gi = gi + 1) begin : g_frame
      if (gi > 0) begin : g_par
        assign body_w[gi] = params[63-8*(gi-1) -: 8];
      end
      assign part_w[gi+1] = part_w[gi] + ((8'(gi) < body_n) ? body_w[gi] : 8'h00);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Sequencer: send frame, await answer, read result packet
  always_ff @(posedge mclk) begin
    if (reset) begin
      state_r        <= HST_IDLE;
      nbody_r        <= 8'h00;
      idx_r          <= 8'h00;
      rsum_r         <= 8'h00;
      h2d_byte_r     <= 8'h00;
      h2d_valid_r    <= 1'b0;
      busy_r         <= 1'b0;
      done_r         <= 1'b0;
      acked_r        <= 1'b0;
      status_valid_r <= 1'b0;
      status_r       <= 8'h00;
      for (int i = 0; i < BUF_BYTES; i++) begin
        body_r[i] <= 8'h00;
      end
    end else begin
      h2d_valid_r <= 1'b0;
      done_r      <= 1'b0;
      case (state_r)
        HST_IDLE: begin
          if (cmd_go) begin
            for (int i = 0; i < BUF_BYTES; i++) begin
              body_r[i] <= body_w[i];
            end
            nbody_r        <= body_n;
            rsum_r         <= part_w[BUF_BYTES];
            busy_r         <= 1'b1;
            status_valid_r <= 1'b0;
            state_r        <= HST_LEN;
          end
        end
        HST_LEN: begin
          h2d_valid_r <= 1'b1;
          h2d_byte_r  <= nbody_r + LEN_HDR;
          state_r     <= HST_SUM;
        end
        HST_SUM: begin
          h2d_valid_r <= 1'b1;
          h2d_byte_r  <= rsum_r;
          idx_r       <= 8'h00;
          state_r     <= HST_BODY;
        end
        HST_BODY: begin
          h2d_valid_r <= 1'b1;
          h2d_byte_r  <= body_r[idx_r[3:0]];
          idx_r       <= idx_r + 8'h01;
          if (idx_r + 8'h01 == nbody_r) begin
            state_r <= HST_WAIT;
          end
        end
        HST_WAIT: begin
          if (rx_nz) begin
            acked_r <= link.d2h_byte == BLC_ACK;
            if (link.d2h_byte == BLC_ACK && body_r[0] == LAST_RESULT_QUERY_CMD) begin
              state_r <= HST_RLEN;
            end else begin
              busy_r  <= 1'b0;
              done_r  <= 1'b1;
              state_r <= HST_IDLE;
            end
          end
        end
        HST_RLEN: begin
          if (rx_nz) begin
            nbody_r <= link.d2h_byte;
            state_r <= HST_RSUM;
          end
        end
        HST_RSUM: begin
          if (link.d2h_valid) begin
            rsum_r  <= link.d2h_byte;
            state_r <= HST_RDAT;
          end
        end
        HST_RDAT: begin
          if (link.d2h_valid) begin
            status_r <= link.d2h_byte;
            // Only a one-byte packet whose sum matches is trusted
            status_valid_r <= (nbody_r == LEN_SHORT) && (rsum_r == link.d2h_byte);
            state_r <= HST_REPL;
          end
        end
        HST_REPL: begin
          h2d_valid_r <= 1'b1;
          h2d_byte_r  <= status_valid_r ? BLC_ACK : BLC_NAK;
          busy_r      <= 1'b0;
          done_r      <= 1'b1;
          state_r     <= HST_IDLE;
        end
        default: begin
          state_r <= HST_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// File: hw/blc_link_if.sv
// Boot loader command engine: byte link between host end and device end.
// Each byte is a one-cycle valid pulse; the receiver always takes it.
`timescale 1ns/1ps
`default_nettype none
interface blc_link_if (
  input wire logic mclk
);
  logic [7:0] h2d_byte;
  logic       h2d_valid;
  logic [7:0] d2h_byte;
  logic       d2h_valid;
  modport dev  (input mclk, input h2d_byte, input h2d_valid,
                output d2h_byte, output d2h_valid);
  modport host (input mclk, output h2d_byte, output h2d_valid,
                input d2h_byte, input d2h_valid);
endinterface
`default_nettype wire

// File: hw/blc_pkg.sv
// Boot loader command engine: shared constants for both link ends.
// Assumes one clock (mclk) and byte-wide links on that clock.
package blc_pkg;
  // Answer bytes
  localparam logic [7:0] BLC_ACK = 8'hCC;
  localparam logic [7:0] BLC_NAK = 8'h33;
  // Command codes
  localparam logic [7:0] CMD_PING              = 8'h20;
  localparam logic [7:0] CMD_DOWNLOAD          = 8'h21;
  localparam logic [7:0] CMD_RUN               = 8'h22;
  localparam logic [7:0] LAST_RESULT_QUERY_CMD = 8'h23;
  localparam logic [7:0] CMD_SEND_DATA         = 8'h24;
  localparam logic [7:0] CMD_RESET             = 8'h25;
  // Packet lengths, counting length and sum bytes
  localparam logic [7:0] LEN_SHORT = 8'h03;
  localparam logic [7:0] LEN_RUN   = 8'h07;
  localparam logic [7:0] LEN_LONG  = 8'h0B;
  localparam logic [7:0] LEN_HDR   = 8'h02;
  // Data bytes kept per packet and payload bytes per programming packet
  localparam int         BUF_BYTES   = 9;
  localparam logic [3:0] PAYLOAD_MAX = 4'h8;
  // Result codes reported on a last-result query
  localparam logic [7:0] RES_SUCCESS = 8'h40;
  localparam logic [7:0] RES_UNKNOWN = 8'h41;
  localparam logic [7:0] RES_INVALID = 8'h42;
  localparam logic [7:0] RES_FAIL    = 8'h43;
  // Device end states
  typedef enum logic [3:0] {
    BLC_IDLE  = 4'b0000,
    BLC_SUM   = 4'b0001,
    BLC_DATA  = 4'b0010,
    BLC_EXEC  = 4'b0011,
    BLC_ERASE = 4'b0100,
    BLC_PROG  = 4'b0101,
    BLC_ANSW  = 4'b0110,
    BLC_STLEN = 4'b0111,
    BLC_STSUM = 4'b1000,
    BLC_STDAT = 4'b1001,
    BLC_STACK = 4'b1010
  } blc_dev_state_t;
endpackage
